// ### core/warmup_pkg.sv
// Constants shared by the oscillator warm-up counter and its helpers.
package warmup_pkg;

    // ------------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------------
    localparam longint SYS_HZ = 100_000_000;
    localparam longint FC_HZ  = 16_000_000;
    localparam longint FS_HZ  = 32_768;

    // Phase steps of the 32-bit accumulators that make the fc and fs ticks.
    localparam logic [31:0] FC_STEP = 32'((FC_HZ << 32) / SYS_HZ);
    localparam logic [31:0] FS_STEP = 32'((FS_HZ << 32) / SYS_HZ);

    // Shortest and longest warm-up intervals in their own units.
    localparam longint SLOW_MIN_US = 7_810;
    localparam longint SLOW_MAX_US = 1_990_000;
    localparam longint FAST_MIN_NS = 16_000;
    localparam longint FAST_MAX_NS = 4_080_000;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LOWER_CTL  = 8'h00;
    localparam logic [7:0] ADDR_UPPER_CTL  = 8'h04;
    localparam logic [7:0] ADDR_PERIOD_LO  = 8'h08;
    localparam logic [7:0] ADDR_PERIOD_HI  = 8'h0C;
    localparam logic [7:0] ADDR_SYSCTL_TWO = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
    localparam logic [7:0] ADDR_COUNT      = 8'h1C;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CTL       = 8'h00;
    localparam logic [7:0] RST_PERIOD    = 8'hFF;
    localparam logic [7:0] RST_SYSCTL    = 8'h80;
    localparam logic [0:0] RST_IRQ       = 1'h0;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int OUT_FF_BIT   = 7;
    localparam int CLK_SEL_HI   = 6;
    localparam int CLK_SEL_LO   = 4;
    localparam int START_BIT    = 3;
    localparam int MODE_HI      = 2;
    localparam int MODE_LO      = 0;

    localparam logic [2:0] CLK_SEL_FS  = 3'h4;
    localparam logic [2:0] CLK_SEL_FC  = 3'h6;
    localparam logic [2:0] MODE_CASCADE = 3'h3;
    localparam logic [2:0] MODE_WARMUP  = 3'h5;

    // System control two fields.
    localparam int FAST_OSC_BIT  = 7;
    localparam int SLOW_OSC_BIT  = 6;
    localparam int SLOW_SYS_BIT  = 5;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : warmup_pkg

// ### core/tick_divider.sv
// Fractional divider that makes one-cycle rate enables from sys_clk.
module tick_divider #(
    parameter logic [31:0] STEP = 32'h0000_0001
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Rate enable
    output logic      tick
);

    logic [31:0] phase;
    logic [32:0] sum;

    assign sum = {1'b0, phase} + {1'b0, STEP};

    // ------------------------------------------------------------------
    // Phase accumulator
    // ------------------------------------------------------------------
    // The carry of the accumulator is the tick, so the mean rate is STEP/2^32 of the sys_clk rate.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            phase <= 32'h0000_0000;
            tick  <= 1'b0;
        end
        else
        begin
            phase <= sum[31:0];
            tick  <= sum[32];
        end
    end

endmodule : tick_divider

// ### core/warmup_count.sv
// Sixteen-bit cascaded up-counter with upper-byte match detection.
module warmup_count (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Control
    input  wire logic        run,
    input  wire logic        tick,
    input  wire logic [7:0]  match_byte,
    // Status
    output logic      [15:0] count,
    output logic             match
);

    logic [15:0] next_count;
    logic [16:0] ticks_seen;

    assign next_count = count + 16'h0001;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            count <= 16'h0000;
            match <= 1'b0;
        end
        else if (!run)
        begin
            count <= 16'h0000;
            match <= 1'b0;
        end
        else if (tick && next_count == {match_byte, 8'h00})
        begin
            count <= 16'h0000;
            match <= 1'b1;
        end
        else
        begin
            count <= tick ? next_count : count;
            match <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Ticks counted since the start or the last match.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !run || match)
            ticks_seen <= {1'b0, 16'h0000} + {16'h0000, run & tick};
        else if (tick)
            ticks_seen <= ticks_seen + 17'h00001;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_match_clears_count: assert property (
        match |-> count == 16'h0000 && $past(run))
        else $error("match without cleared count");

    // The tick that matches is already in ticks_seen when the pulse shows.
    a_interval_length: assert property (
        $rose(match) |-> ticks_seen == {1'b0, match_byte, 8'h00}
            || (match_byte == 8'h00 && ticks_seen == 17'h10000))
        else $error("warm-up interval length wrong");

    a_low_byte_ignored: assert property (
        match |-> $past(count, 1) == {match_byte, 8'h00} - 16'h0001)
        else $error("match on wrong count");

    a_stop_zeroes: assert property (
        !run |=> count == 16'h0000 && !match)
        else $error("stopped counter not zero");

endmodule : warmup_count

// ### core/oscillator_warmup_counter.sv
// Warm-up counter with oscillator controls behind an AXI4-Lite slave.

// Contract
// - Once started in warm-up mode the counter counts up to the period, clears and raises the match interrupt.
// - On the slow clock the interval spans 7.81 ms at 0100H to 1.99 s at FF00H.
// - On the fast clock the interval spans 16 us at 0100H to 4.08 ms at FF00H.
// - Lower control 43H selects the slow source in cascade, 63H the fast source.
// - Upper control 05H selects warm-up mode with output flip-flop cleared and the timer stopped.
// - System control two bit 7 enables the fast oscillator, bit 6 the slow one, bit 5 picks the slow system clock.
// - Only the upper period byte takes part in the match; the lower byte is ignored.
module oscillator_warmup_counter (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Interrupts
    output logic             irq,
    output logic             cascade_match_irq,
    // Oscillator and clock controls
    output logic             fast_osc_enable,
    output logic             slow_osc_enable,
    output logic             slow_clock_select,
    // Timer output flip-flops
    output logic             upper_output_ff,
    output logic             lower_output_ff
);

    logic [7:0]  lower_timer_control;
    logic [7:0]  upper_timer_control;
    logic [7:0]  period_reg_lower;
    logic [7:0]  period_reg_upper;
    logic [7:0]  system_control_two;
    logic        irq_status;
    logic        irq_mask;

    logic        fc_tick;
    logic        fs_tick;
    logic        tick;
    logic        run;
    logic [2:0]  clk_sel;
    logic [15:0] count;
    logic        match;

    logic        wr_go;
    logic        wr_lane;
    logic        wr_hit;
    logic        rd_go;
    logic        rd_hit;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------------
    // Rate enables and counter
    // ------------------------------------------------------------------
    tick_divider #(
        .STEP    (warmup_pkg::FC_STEP)
    ) u_fc_div (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tick    (fc_tick)
    );

    tick_divider #(
        .STEP    (warmup_pkg::FS_STEP)
    ) u_fs_div (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tick    (fs_tick)
    );

    assign clk_sel = lower_timer_control[warmup_pkg::CLK_SEL_HI:
                                         warmup_pkg::CLK_SEL_LO];

    // Only the fs and fc sources count; other selections hold the count.
    always_comb
    begin
        case (clk_sel)
            warmup_pkg::CLK_SEL_FS: tick = fs_tick;
            warmup_pkg::CLK_SEL_FC: tick = fc_tick;
            default:                tick = 1'b0;
        endcase
    end

    // The pair runs only with the lower timer in cascade and the upper
    // timer in warm-up mode, and only while the start bit is set.
    assign run = upper_timer_control[warmup_pkg::START_BIT]
        && upper_timer_control[warmup_pkg::MODE_HI:warmup_pkg::MODE_LO]
           == warmup_pkg::MODE_WARMUP
        && lower_timer_control[warmup_pkg::MODE_HI:warmup_pkg::MODE_LO]
           == warmup_pkg::MODE_CASCADE;

    warmup_count u_count (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .run        (run),
        .tick       (tick),
        .match_byte (period_reg_upper),
        .count      (count),
        .match      (match)
    );

    assign cascade_match_irq = match;

    // ------------------------------------------------------------------
    // Oscillator controls and output flip-flops
    // ------------------------------------------------------------------
    assign fast_osc_enable   = system_control_two[warmup_pkg::FAST_OSC_BIT];
    assign slow_osc_enable   = system_control_two[warmup_pkg::SLOW_OSC_BIT];
    assign slow_clock_select = system_control_two[warmup_pkg::SLOW_SYS_BIT];

    // Warm-up mode never toggles the flip-flops; they show their initial
    // value, loaded whenever the timer is stopped.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            upper_output_ff <= 1'b0;
            lower_output_ff <= 1'b0;
        end
        else if (!run)
        begin
            upper_output_ff <= upper_timer_control[warmup_pkg::OUT_FF_BIT];
            lower_output_ff <= lower_timer_control[warmup_pkg::OUT_FF_BIT];
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    // Address and data are taken together in one cycle.
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign wr_lane       = wr_go && s_axi_wstrb[0];

    always_comb
    begin
        case (s_axi_awaddr)
            warmup_pkg::ADDR_LOWER_CTL,
            warmup_pkg::ADDR_UPPER_CTL,
            warmup_pkg::ADDR_PERIOD_LO,
            warmup_pkg::ADDR_PERIOD_HI,
            warmup_pkg::ADDR_SYSCTL_TWO,
            warmup_pkg::ADDR_IRQ_STATUS,
            warmup_pkg::ADDR_IRQ_MASK,
            warmup_pkg::ADDR_COUNT:     wr_hit = 1'b1;
            default:                    wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= warmup_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? warmup_pkg::RESP_OKAY
                                   : warmup_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            lower_timer_control <= warmup_pkg::RST_CTL;
            upper_timer_control <= warmup_pkg::RST_CTL;
            period_reg_lower    <= warmup_pkg::RST_PERIOD;
            period_reg_upper    <= warmup_pkg::RST_PERIOD;
            system_control_two  <= warmup_pkg::RST_SYSCTL;
            irq_mask            <= warmup_pkg::RST_IRQ;
        end
        else if (wr_lane)
        begin
            case (s_axi_awaddr)
                warmup_pkg::ADDR_LOWER_CTL:
                    lower_timer_control <= s_axi_wdata[7:0];
                warmup_pkg::ADDR_UPPER_CTL:
                    upper_timer_control <= s_axi_wdata[7:0];
                warmup_pkg::ADDR_PERIOD_LO:
                    period_reg_lower    <= s_axi_wdata[7:0];
                warmup_pkg::ADDR_PERIOD_HI:
                    period_reg_upper    <= s_axi_wdata[7:0];
                warmup_pkg::ADDR_SYSCTL_TWO:
                    system_control_two  <= s_axi_wdata[7:0];
                warmup_pkg::ADDR_IRQ_MASK:
                    irq_mask            <= s_axi_wdata[0];
                default:
                    irq_mask            <= irq_mask;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    // A match in the same cycle as a write-one-to-clear keeps the bit set.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            irq_status <= warmup_pkg::RST_IRQ;
        else if (match)
            irq_status <= 1'b1;
        else if (wr_lane && s_axi_awaddr == warmup_pkg::ADDR_IRQ_STATUS
                 && s_axi_wdata[0])
            irq_status <= 1'b0;
    end

    assign irq = irq_status && irq_mask;

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go         = s_axi_arvalid && !s_axi_rvalid;

    always_comb
    begin
        rd_hit     = 1'b1;
        next_rdata = 32'h0000_0000;
        case (s_axi_araddr)
            warmup_pkg::ADDR_LOWER_CTL:
                next_rdata[7:0] = lower_timer_control;
            warmup_pkg::ADDR_UPPER_CTL:
                next_rdata[7:0] = upper_timer_control;
            warmup_pkg::ADDR_PERIOD_LO:
                next_rdata[7:0] = period_reg_lower;
            warmup_pkg::ADDR_PERIOD_HI:
                next_rdata[7:0] = period_reg_upper;
            warmup_pkg::ADDR_SYSCTL_TWO:
                next_rdata[7:0] = system_control_two;
            warmup_pkg::ADDR_IRQ_STATUS:
                next_rdata[0] = irq_status;
            warmup_pkg::ADDR_IRQ_MASK:
                next_rdata[0] = irq_mask;
            warmup_pkg::ADDR_COUNT:
                next_rdata[15:0] = count;
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= warmup_pkg::RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rd_hit ? warmup_pkg::RESP_OKAY
                                   : warmup_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_match_sets_status: assert property (
        match |=> irq_status ##0 (irq == irq_mask))
        else $error("match did not set status");

    a_slow_source: assert property (
        run && clk_sel == warmup_pkg::CLK_SEL_FS |-> tick == fs_tick)
        else $error("slow source not selected");

    a_fast_source: assert property (
        run && clk_sel == warmup_pkg::CLK_SEL_FC |-> tick == fc_tick)
        else $error("fast source not selected");

    a_warmup_idle: assert property (
        wr_lane && s_axi_awaddr == warmup_pkg::ADDR_UPPER_CTL
        && s_axi_wdata[7:0] == 8'h05 |=> !run ##1 !match)
        else $error("warm-up setup started the timer");

    a_start_runs: assert property (
        wr_lane && s_axi_awaddr == warmup_pkg::ADDR_UPPER_CTL
        && s_axi_wdata[7:0] == 8'h0D && lower_timer_control == 8'h43
        |=> run)
        else $error("start bit did not run the pair");

    a_osc_pins: assert property (
        wr_lane && s_axi_awaddr == warmup_pkg::ADDR_SYSCTL_TWO
        |=> fast_osc_enable == $past(s_axi_wdata[7])
            && slow_osc_enable == $past(s_axi_wdata[6])
            && slow_clock_select == $past(s_axi_wdata[5]))
        else $error("oscillator controls wrong");

    a_stop_clears: assert property (
        $fell(run) |=> (count == 16'h0000) [*2])
        else $error("stop did not clear the count");

    // Between matches the count only steps on ticks; the lower period
    // byte never loads or clears it.
    a_period_lower_free: assert property (
        run && $past(run) && !match
        |-> count == $past(count) + {15'h0000, $past(tick)})
        else $error("lower period byte affected count");

endmodule : oscillator_warmup_counter

// ### verif/tb_top.sv
// Self-checking bench for the oscillator warm-up counter over AXI4-Lite.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk;
    logic        reset_n;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        irq;
    logic        cascade_match_irq;
    logic        fast_osc_enable;
    logic        slow_osc_enable;
    logic        slow_clock_select;
    logic        upper_output_ff;
    logic        lower_output_ff;
    logic [31:0] rd_data;
    int          n_errors;
    int          compares;

    oscillator_warmup_counter uut (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq),
        .cascade_match_irq(cascade_match_irq),
        .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
        .slow_clock_select(slow_clock_select),
        .upper_output_ff(upper_output_ff), .lower_output_ff(lower_output_ff)
    );

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Address and data are offered together and released as each is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] exp_resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (aw_done && w_done && s_axi_bvalid)
            begin
                chk({30'h0, s_axi_bresp}, {30'h0, exp_resp});
                break;
            end
            if (s_axi_awready && !aw_done)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_done)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] exp_resp);
        logic ar_done;
        ar_done = 1'b0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (ar_done && s_axi_rvalid)
            begin
                rd_data = s_axi_rdata;
                chk({30'h0, s_axi_rresp}, {30'h0, exp_resp});
                break;
            end
            if (s_axi_arready && !ar_done)
            begin
                ar_done = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, warmup_pkg::RESP_OKAY);
        chk(rd_data, exp);
    endtask : rdc

    task automatic wro(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, warmup_pkg::RESP_OKAY);
    endtask : wro

    // Start a warm-up and measure cycles from start to the match pulse.
    task automatic fast_run(input logic [7:0] hi, input logic [7:0] lo,
                            input int exp);
        int n;
        wro(warmup_pkg::ADDR_PERIOD_LO, {24'h0, lo});
        wro(warmup_pkg::ADDR_PERIOD_HI, {24'h0, hi});
        wro(warmup_pkg::ADDR_UPPER_CTL, 32'h0D);
        n = 0;
        while (cascade_match_irq !== 1'b1 && n < 8000)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, (n >= exp - 10 && n <= exp + 10)}, 32'h1);
        @(posedge sys_clk);
        chk(cascade_match_irq, 1'b0);
        wro(warmup_pkg::ADDR_UPPER_CTL, 32'h05);
        rdc(warmup_pkg::ADDR_COUNT, 32'h0);
        rdc(warmup_pkg::ADDR_IRQ_STATUS, 32'h1);
    endtask : fast_run

    task automatic osc_chk(input logic [2:0] exp);
        chk({29'h0, fast_osc_enable, slow_osc_enable, slow_clock_select},
            {29'h0, exp});
    endtask : osc_chk

    task automatic end_sim;
        $display("Run ended: %0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        $display("Error at %0t: timeout got %h expected %h", $time, 0, 1);
        end_sim();
    end

    initial
    begin
        n_errors = 0;
        compares = 0;
        reset_n = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdc(warmup_pkg::ADDR_SYSCTL_TWO, 32'h80);
        rdc(warmup_pkg::ADDR_PERIOD_HI, 32'hFF);
        rdc(warmup_pkg::ADDR_UPPER_CTL, 32'h00);
        rdc(warmup_pkg::ADDR_COUNT, 32'h0);
        osc_chk(3'h4);
        wr(8'h20, 32'h5A, warmup_pkg::RESP_SLVERR);
        rd(8'h20, warmup_pkg::RESP_SLVERR);
        chk(rd_data, 32'h0);
        $display("Test reset and map done");
        wro(warmup_pkg::ADDR_SYSCTL_TWO, 32'hE0);
        osc_chk(3'h7);
        wro(warmup_pkg::ADDR_LOWER_CTL, 32'h63);
        wro(warmup_pkg::ADDR_UPPER_CTL, 32'h05);
        wro(warmup_pkg::ADDR_IRQ_MASK, 32'h0);
        fast_run(8'h01, 8'h00, 1600);
        chk(irq, 1'b0);
        wro(warmup_pkg::ADDR_IRQ_MASK, 32'h1);
        chk(irq, 1'b1);
        wro(warmup_pkg::ADDR_IRQ_STATUS, 32'h1);
        chk(irq, 1'b0);
        rdc(warmup_pkg::ADDR_IRQ_STATUS, 32'h0);
        fast_run(8'h02, 8'hFF, 3200);
        chk(irq, 1'b1);
        wro(warmup_pkg::ADDR_IRQ_STATUS, 32'h1);
        wro(warmup_pkg::ADDR_SYSCTL_TWO, 32'hC0);
        osc_chk(3'h6);
        wro(warmup_pkg::ADDR_SYSCTL_TWO, 32'h80);
        osc_chk(3'h4);
        $display("Test fast warm-up done");
        wro(warmup_pkg::ADDR_SYSCTL_TWO, 32'hC0);
        wro(warmup_pkg::ADDR_LOWER_CTL, 32'h43);
        wro(warmup_pkg::ADDR_UPPER_CTL, 32'h05);
        wro(warmup_pkg::ADDR_PERIOD_HI, 32'h80);
        wro(warmup_pkg::ADDR_UPPER_CTL, 32'h0D);
        repeat (30000) @(posedge sys_clk);
        rd(warmup_pkg::ADDR_COUNT, warmup_pkg::RESP_OKAY);
        chk({31'h0, (rd_data == 9 || rd_data == 10)}, 32'h1);
        wro(warmup_pkg::ADDR_UPPER_CTL, 32'h05);
        rdc(warmup_pkg::ADDR_COUNT, 32'h0);
        wro(warmup_pkg::ADDR_SYSCTL_TWO, 32'hE0);
        wro(warmup_pkg::ADDR_SYSCTL_TWO, 32'h60);
        osc_chk(3'h3);
        chk({30'h0, upper_output_ff, lower_output_ff}, 32'h0);
        $display("Test slow warm-up done");
        end_sim();
    end
endmodule : tb_top
